//--- sim/rtc_control_status_irq_test.sv
// Self-checking bench for control, flag and status registers
`timescale 1ns/1ps
`default_nettype none
module rtc_control_status_irq_test import rtc_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic oscPin = 1'b0;
  logic rstPinN = 1'b1;
  logic backupOk = 1'b1;
  logic [3:0] rateSelect = 4'h0;
  logic [7:0] tSec = 8'h00;
  logic [7:0] tMin = 8'h00;
  logic [7:0] tHour = 8'h00;
  logic [7:0] aSec = 8'h01;
  logic [7:0] aMin = 8'h02;
  logic [7:0] aHour = 8'h03;
  logic addrStrobe, dataStrobe, readNotWrite, chipEnN, adOe;
  logic irqOut, irqOe, sqwPin, updateInProgress, updateTransfer;
  logic binaryMode, hour24Mode, daylightSavingEn;
  logic [7:0] adIn, adOut, junk;
  logic seen0, seen1;
  int errCount = 0;
  int samplesChecked = 0;
  int cyc = 0;
  int hi;
  localparam int LEAD = 20;

  // Clock, 100 MHz, and a fast oscillator of two clocks a period,
  // so that one update cycle falls inside the run
  always #5 clk = ~clk;
  always begin
    @(negedge clk);
    oscPin = ~oscPin;
  end

  rtc_host_model host (.clk(clk), .adOut(adOut), .adOe(adOe),
    .addrStrobe(addrStrobe), .dataStrobe(dataStrobe),
    .readNotWrite(readNotWrite), .chipEnN(chipEnN), .adIn(adIn));

  rtc_control_status #(.LEAD_CYCLES(LEAD)) DUT (.clk(clk), .nrst(nrst),
    .oscPin(oscPin), .rstPinN(rstPinN), .backupOk(backupOk),
    .addrStrobe(addrStrobe), .dataStrobe(dataStrobe),
    .readNotWrite(readNotWrite), .chipEnN(chipEnN), .adIn(adIn),
    .adOut(adOut), .adOe(adOe), .irqOut(irqOut), .irqOe(irqOe),
    .sqwPin(sqwPin), .rateSelect(rateSelect), .timeSec(tSec),
    .timeMin(tMin), .timeHour(tHour), .alarmSec(aSec), .alarmMin(aMin),
    .alarmHour(aHour), .updateInProgress(updateInProgress),
    .updateTransfer(updateTransfer), .binaryMode(binaryMode),
    .hour24Mode(hour24Mode), .daylightSavingEn(daylightSavingEn));

  // Verdict and end of run
  task automatic closeOut();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : closeOut

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samplesChecked++;
    if (g !== e) begin
      errCount++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.acc(a, 1'b1, 8'h00, q);
    chk(q, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.acc(a, 1'b0, d, q);
  endtask : wr

  // Hang guard, well above the first update cycle near 33000 clocks
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      errCount++;
      $display("[ERR] %0t cycle limit reached", $time);
      closeOut();
    end
  end

  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_STATUS, 8'h80);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'h80);
    backupOk = 1'b0;
    rd(ADDR_STATUS, 8'h00);
    backupOk = 1'b1;
    rd(ADDR_FLAGS, 8'h00);
    $display("test reset values done");
    wr(ADDR_CONTROL, 8'hff);
    rd(ADDR_CONTROL, 8'hef);
    chk({5'h00, binaryMode, hour24Mode, daylightSavingEn}, 8'h07);
    rstPinN = 1'b0;
    repeat (6) @(negedge clk);
    rstPinN = 1'b1;
    repeat (4) @(negedge clk);
    rd(ADDR_CONTROL, 8'h87);
    wr(ADDR_FLAGS, 8'hff);
    rd(ADDR_FLAGS, 8'h00);
    $display("test control and reset pin done");
    rateSelect = 4'h6;
    wr(ADDR_CONTROL, 8'h48);
    for (int i = 0; i < 3000 && irqOe !== 1'b1; i++) @(negedge clk);
    chk({7'h00, irqOe}, 8'h01);
    rd(ADDR_FLAGS, 8'hc0);
    chk({7'h00, irqOe}, 8'h00);
    seen0 = 1'b0;
    seen1 = 1'b0;
    repeat (600) begin
      @(negedge clk);
      seen0 |= (sqwPin === 1'b0);
      seen1 |= (sqwPin === 1'b1);
    end
    chk({6'h00, seen1, seen0}, 8'h03);
    // Code six picks the 1.024 kHz stage: high 32 of every 64 clocks
    hi = 0;
    repeat (128) begin
      @(negedge clk);
      hi += (sqwPin === 1'b1);
    end
    chk(hi[7:0], 8'h40);
    // Code one picks the 256 Hz stage: high 128 of every 256 clocks
    rateSelect = 4'h1;
    repeat (20) @(negedge clk);
    hi = 0;
    repeat (256) begin
      @(negedge clk);
      hi += (sqwPin === 1'b1);
    end
    chk(hi[7:0], 8'h80);
    wr(ADDR_CONTROL, 8'h00);
    repeat (600) @(negedge clk);
    chk({6'h00, irqOe, sqwPin}, 8'h00);
    rd(ADDR_FLAGS, 8'h40);
    $display("test periodic and square wave done");
    rateSelect = 4'h0;
    repeat (20) @(negedge clk);
    host.acc(ADDR_FLAGS, 1'b1, 8'h00, junk);
    repeat (600) @(negedge clk);
    rd(ADDR_FLAGS, 8'h00);
    $display("test rate none done");
    // One update cycle: hours don't-care, minutes and seconds equal
    aSec = 8'h00;
    aMin = 8'h00;
    aHour = 8'hc0;
    wr(ADDR_CONTROL, 8'h30);
    for (int i = 0; i < 40000 && updateInProgress !== 1'b1; i++)
      @(negedge clk);
    hi = 0;
    while (updateInProgress === 1'b1 && hi < 100) begin
      hi++;
      @(negedge clk);
    end
    chk(hi[7:0], 8'(LEAD));
    chk({5'h00, updateTransfer, irqOe, irqOut}, 8'h06);
    rd(ADDR_FLAGS, 8'hb0);
    chk({7'h00, irqOe}, 8'h00);
    $display("test update cycle done");
    closeOut();
  end
endmodule : rtc_control_status_irq_test
`default_nettype wire

//--- sim/rtc_host_model.sv
// Host processor model driving the multiplexed register bus
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
  input wire logic clk, // System clock
  input wire logic [7:0] adOut, // Device data drive
  input wire logic adOe, // Device drives the bus
  output logic addrStrobe, // Address strobe pin
  output logic dataStrobe, // Data strobe pin
  output logic readNotWrite, // High for read
  output logic chipEnN, // Chip enable, active low
  output logic [7:0] adIn // Resolved bus level
);
  logic [7:0] drv;
  logic hostOe;

  // Released bus shows the inverse of the last value, never stale data
  assign adIn = adOe ? adOut : (hostOe ? drv : ~drv);

  // Idle pins at time zero
  initial begin
    drv = 8'h00;
    hostOe = 1'b0;
    addrStrobe = 1'b0;
    dataStrobe = 1'b0;
    readNotWrite = 1'b1;
    chipEnN = 1'b1;
  end

  // One byte access; address strobe held six clocks and address twelve, changes at falling edge
  task automatic acc(input logic [7:0] a, input logic rd,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    q = 8'h00;
    @(negedge clk);
    chipEnN = 1'b0;
    readNotWrite = rd;
    addrStrobe = 1'b1;
    drv = a;
    hostOe = 1'b1;
    repeat (6) @(negedge clk);
    addrStrobe = 1'b0;
    repeat (6) @(negedge clk);
    drv = d;
    hostOe = !rd;
    dataStrobe = 1'b1;
    if (rd) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (adOe !== 1'b1 && n < 40);
      q = adOut;
    end else begin
      repeat (6) @(posedge clk);
    end
    @(negedge clk);
    dataStrobe = 1'b0;
    repeat (8) @(negedge clk);
    chipEnN = 1'b1;
    hostOe = 1'b0;
  endtask : acc
endmodule : rtc_host_model
`default_nettype wire

//--- src/rtc_control_status.sv
// Control, flag and status registers with interrupt and update timing
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: Inhibit bit zero lets updates advance time
// RULE2: Inhibit bit changes only by software write
// RULE3: Periodic enable gates interrupt, flag always sets
// RULE4: Periodic enable cleared by reset pin
// RULE5: Alarm on byte match, don't-care bytes match
// RULE6: Alarm enable cleared by reset pin only
// RULE7: Update enable cleared by pin or inhibit
// RULE8: Square wave out when enabled, else low
// RULE9: Number format bit, software only
// RULE10: Hour format bit, software only
// RULE11: Daylight saving bit, software only
// RULE12: Control bits inhibit down to daylight saving
// RULE13: Combined flag is any flag with enable
// RULE14: Periodic flag sets on tap edge
// RULE15: Alarm flag set on match, cleared on read
// RULE16: Update flag set after every update cycle
// RULE17: Flag register layout, low nibble zero
// RULE18: Status bit seven shows backup cell health
// RULE19: Status bits six to zero read zero
// RULE20: Setting inhibit drops progress flag and transfer
// RULE21: Rate code picks tap, zero means none
// RULE22: Flag read returns old values, then clears
// RULE23: Host reads flags before leaving service
module rtc_control_status import rtc_pkg::*; #(
  parameter int unsigned LEAD_CYCLES = UIP_LEAD_CYCLES // Progress lead
) (
  input wire logic clk,              // System clock, 100 MHz
  input wire logic nrst,             // Asynchronous reset, active low
  input wire logic oscPin,           // 32.768 kHz oscillator input
  input wire logic rstPinN,          // Device reset pin, active low
  input wire logic backupOk,         // Backup cell healthy
  input wire logic addrStrobe,       // Address strobe pin
  input wire logic dataStrobe,       // Data strobe pin
  input wire logic readNotWrite,     // High for read, low for write
  input wire logic chipEnN,          // Chip enable, active low
  input wire logic [7:0] adIn,       // Address/data bus, input side
  output logic [7:0] adOut,          // Address/data bus, output side
  output logic adOe,                 // Bus output enable
  output logic irqOut,               // Interrupt pin level, always low
  output logic irqOe,                // Interrupt pin pulled low
  output logic sqwPin,               // Square wave pin
  input wire logic [3:0] rateSelect, // Rate code from rate register
  input wire logic [7:0] timeSec,    // Current seconds byte
  input wire logic [7:0] timeMin,    // Current minutes byte
  input wire logic [7:0] timeHour,   // Current hours byte
  input wire logic [7:0] alarmSec,   // Alarm seconds byte
  input wire logic [7:0] alarmMin,   // Alarm minutes byte
  input wire logic [7:0] alarmHour,  // Alarm hours byte
  output logic updateInProgress,     // Update soon to transfer
  output logic updateTransfer,       // One cycle: advance counters
  output logic binaryMode,           // Binary when high, BCD when low
  output logic hour24Mode,           // 24-hour when high
  output logic daylightSavingEn      // Enables daylight saving jumps
);

  typedef struct packed {
    logic [1:0] osc;
    logic [1:0] as;
    logic [1:0] ds;
    logic [1:0] rw;
    logic [1:0] ce;
    logic [1:0] rstp;
    logic [1:0] valid;
    logic [7:0] ad1;
    logic [7:0] ad2;
    logic oscPrev;
    logic asPrev;
    logic dsPrev;
    logic oscTick;
    logic [7:0] addr;
    logic sel;
    logic [7:0] ctrl;
    logic [2:0] flags;
    logic combined;
    upd_state_t upd;
    logic [LEAD_W-1:0] cnt;
    logic update_in_progress;
    logic xfer;
    logic [7:0] adOut;
    logic adOe;
    logic irqOe;
    logic irqOut;
    logic square_wave_pin;
  } ctl_state_t;

  ctl_state_t s;
  ctl_state_t n;

  logic tapLevel;
  logic periodicPulse;
  logic secondPulse;
  logic asFall;
  logic dsRise;
  logic dsFall;
  logic pinRst;
  logic wrCtl;
  logic rdFlagsEnd;
  logic updEnd;
  logic alarmHit;
  logic [7:0] rdData;
  logic rdMapped;
  logic [2:0] flagEn;
  logic [2:0][7:0] timeBytes;
  logic [2:0][7:0] alarmBytes;
  logic [2:0] byteMatch;

  // Divider chain fed by the synchronised oscillator tick
  rtc_divider u_divider (
    .clk(clk),
    .nrst(nrst),
    .oscTick(s.oscTick),
    .rateSelect(rateSelect),
    .tapLevel(tapLevel),
    .periodicPulse(periodicPulse),
    .secondPulse(secondPulse)
  );

  // Alarm comparison per byte, don't-care code matches anything
  assign timeBytes = {timeHour, timeMin, timeSec};
  assign alarmBytes = {alarmHour, alarmMin, alarmSec};
  for (genvar i = 0; i < 3; i++) begin : g_alarm
    assign byteMatch[i] = ((alarmBytes[i] & DONT_CARE_MASK) == DONT_CARE_MASK)
        || (alarmBytes[i] == timeBytes[i]); // [RULE5]
  end
  assign alarmHit = &byteMatch;

  // Next-state logic
  always_comb begin
    n = s;
    // Pin synchronisers, first stage feeds only the second
    n.osc = {s.osc[0], oscPin};
    n.as = {s.as[0], addrStrobe};
    n.ds = {s.ds[0], dataStrobe};
    n.rw = {s.rw[0], readNotWrite};
    n.ce = {s.ce[0], chipEnN};
    n.rstp = {s.rstp[0], rstPinN};
    n.valid = {s.valid[0], backupOk};
    n.ad1 = adIn;
    n.ad2 = s.ad1;
    n.oscPrev = s.osc[1];
    n.asPrev = s.as[1];
    n.dsPrev = s.ds[1];
    n.oscTick = s.osc[1] & ~s.oscPrev;
    asFall = s.asPrev & ~s.as[1];
    dsRise = ~s.dsPrev & s.ds[1];
    dsFall = s.dsPrev & ~s.ds[1];
    pinRst = ~s.rstp[1];

    // Address phase: latch address when strobe falls
    if (asFall) begin
      n.addr = s.ad2;
      n.sel = ~s.ce[1];
    end
    wrCtl = dsFall & s.sel & ~s.rw[1] & (s.addr == ADDR_CONTROL);
    rdFlagsEnd = dsFall & s.sel & s.rw[1] & (s.addr == ADDR_FLAGS);

    // Read data selection
    rdMapped = 1'b1;
    if (s.addr == ADDR_CONTROL) begin
      rdData = s.ctrl;
    end else if (s.addr == ADDR_FLAGS) begin
      rdData = {s.combined, s.flags, FLG_UNUSED}; // [RULE17]
    end else if (s.addr == ADDR_STATUS) begin
      rdData = {s.valid[1], STS_UNUSED}; // [RULE18] [RULE19]
    end else begin
      rdData = 8'h00;
      rdMapped = 1'b0;
    end

    // Data phase: drive while strobe is high on a mapped read
    if (dsRise & s.sel & s.rw[1] & rdMapped) begin
      n.adOut = rdData; // [RULE22]
      n.adOe = 1'b1;
    end else if (dsFall) begin
      n.adOe = 1'b0;
    end

    // Control register write; inhibit rising clears update enable
    if (wrCtl) begin
      n.ctrl = s.ad2; // [RULE12] [RULE2] [RULE9] [RULE10] [RULE11]
      if (s.ad2[CTL_INHIBIT] & ~s.ctrl[CTL_INHIBIT]) begin
        n.ctrl[CTL_UIE] = 1'b0; // [RULE7]
      end
    end
    // Reset pin clears only the enables it owns
    if (pinRst) begin
      n.ctrl[CTL_PIE] = 1'b0; // [RULE4]
      n.ctrl[CTL_AIE] = 1'b0; // [RULE6]
      n.ctrl[CTL_UIE] = 1'b0; // [RULE7]
      n.ctrl[CTL_SQUARE_WAVE_ENABLE] = 1'b0; // [RULE8]
    end

    // Update cycle: progress lead, then transfer and end
    updEnd = 1'b0;
    case (s.upd)
      UPD_IDLE: begin
        if (secondPulse) begin
          n.upd = UPD_LEAD;
          n.cnt = '0;
        end
      end
      UPD_LEAD: begin
        if (s.cnt == LEAD_W'(LEAD_CYCLES - 1)) begin
          n.upd = UPD_IDLE;
          updEnd = 1'b1;
        end else begin
          n.cnt = s.cnt + 1'b1;
        end
      end
    endcase
    n.update_in_progress = (n.upd == UPD_LEAD) & ~n.ctrl[CTL_INHIBIT]; // [RULE20]
    n.xfer = updEnd & ~n.ctrl[CTL_INHIBIT]; // [RULE1] [RULE20]

    // Flags: pin reset wins, otherwise a new event beats the read clear
    if (pinRst) begin
      n.flags = FLG_RESET; // [RULE14] [RULE15] [RULE16]
    end else begin
      n.flags = s.flags & ~{3{rdFlagsEnd}}; // [RULE22]
      n.flags[FLG_PERIODIC] = n.flags[FLG_PERIODIC] | periodicPulse; // [RULE14]
      n.flags[FLG_ALARM] = n.flags[FLG_ALARM] | (updEnd & alarmHit); // [RULE15]
      n.flags[FLG_UPDATE] = n.flags[FLG_UPDATE] | updEnd; // [RULE16]
    end
    flagEn = {n.ctrl[CTL_PIE], n.ctrl[CTL_AIE], n.ctrl[CTL_UIE]};
    n.combined = |(n.flags & flagEn); // [RULE13] [RULE3]
    n.irqOe = n.combined; // [RULE13]
    n.irqOut = 1'b0;
    n.square_wave_pin = s.ctrl[CTL_SQUARE_WAVE_ENABLE] & tapLevel; // [RULE8] [RULE21]
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.ctrl <= CTL_RESET;
      s.upd <= UPD_IDLE;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign adOut = s.adOut;
  assign adOe = s.adOe;
  assign irqOut = s.irqOut;
  assign irqOe = s.irqOe;
  assign sqwPin = s.square_wave_pin;
  assign updateInProgress = s.update_in_progress;
  assign updateTransfer = s.xfer;
  assign binaryMode = s.ctrl[CTL_NUMFMT];
  assign hour24Mode = s.ctrl[CTL_HOUR24];
  assign daylightSavingEn = s.ctrl[CTL_DST];

  a_inhibit_blocks_xfer: assert property (@(posedge clk) disable iff (!nrst) // [RULE1]
    s.ctrl[CTL_INHIBIT] |-> !updateTransfer && !updateInProgress)
    else $error("Update transfer while inhibited");

  a_inhibit_write_only: assert property (@(posedge clk) disable iff (!nrst) // [RULE2]
    $changed(s.ctrl[CTL_INHIBIT]) |-> $past(wrCtl))
    else $error("Inhibit bit changed without a write");

  a_pin_clears_enables: assert property (@(posedge clk) disable iff (!nrst) // [RULE4]
    pinRst |=> !s.ctrl[CTL_PIE] && !s.ctrl[CTL_AIE] && !s.ctrl[CTL_SQUARE_WAVE_ENABLE]
      && !s.ctrl[CTL_UIE] && s.flags == FLG_RESET)
    else $error("Reset pin left an enable or flag set");

  a_periodic_sets: assert property (@(posedge clk) disable iff (!nrst) // [RULE14]
    periodicPulse && !pinRst |=> s.flags[FLG_PERIODIC])
    else $error("Periodic flag missed a tap edge");

  a_alarm_sets: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
    updEnd && alarmHit && !pinRst |=> s.flags[FLG_ALARM] && s.flags[FLG_UPDATE])
    else $error("Alarm or update flag missed");

  a_uie_on_inhibit: assert property (@(posedge clk) disable iff (!nrst) // [RULE7]
    $rose(s.ctrl[CTL_INHIBIT]) |-> !s.ctrl[CTL_UIE])
    else $error("Update enable kept when inhibit rose");

  a_sqw_low: assert property (@(posedge clk) disable iff (!nrst) // [RULE8]
    !s.ctrl[CTL_SQUARE_WAVE_ENABLE] |=> !sqwPin)
    else $error("Square wave pin driven while disabled");

  a_irq_cause: assert property (@(posedge clk) disable iff (!nrst) // [RULE13]
    irqOe == |(s.flags & {s.ctrl[CTL_PIE], s.ctrl[CTL_AIE], s.ctrl[CTL_UIE]})
      && irqOe == s.combined)
    else $error("Interrupt pin disagrees with flags and enables");

  a_read_clears: assert property (@(posedge clk) disable iff (!nrst) // [RULE22]
    rdFlagsEnd && !periodicPulse && !updEnd |=> s.flags == FLG_RESET && !irqOe)
    else $error("Flag read did not clear the flags");

  a_lead_time: assert property (@(posedge clk) disable iff (!nrst) // [RULE20]
    $rose(s.upd == UPD_LEAD) |-> (s.upd == UPD_LEAD) [*8])
    else $error("Update lead ended too early");

endmodule : rtc_control_status
`default_nettype wire

//--- src/rtc_divider.sv
// Fifteen stage divider chain with rate tap and one second tick
`timescale 1ns/1ps
`default_nettype none
module rtc_divider import rtc_pkg::*; (
  input wire logic clk,              // System clock
  input wire logic nrst,             // Asynchronous reset, active low
  input wire logic oscTick,          // One pulse per oscillator period
  input wire logic [3:0] rateSelect, // Rate code for tap choice
  output logic tapLevel,             // Selected tap level
  output logic periodicPulse,        // Rising edge of selected tap
  output logic secondPulse           // One pulse per second
);

  typedef struct packed {
    logic [DIV_STAGES-1:0] count;
    logic tap;
    logic pp;
    logic sp;
  } div_state_t;

  div_state_t s;
  div_state_t n;

  // Count oscillator ticks and pick the tap
  always_comb begin
    n = s;
    if (oscTick) begin
      n.count = s.count + 1'b1;
    end
    n.tap = (rateSelect != RATE_NONE) & n.count[tap_index(rateSelect)]; // [RULE21]
    n.pp = n.tap & ~s.tap; // [RULE14]
    n.sp = n.count[SECOND_TAP] & ~s.count[SECOND_TAP];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tapLevel = s.tap;
  assign periodicPulse = s.pp;
  assign secondPulse = s.sp;

  a_no_rate_none: assert property (@(posedge clk) disable iff (!nrst) // [RULE21]
    (rateSelect == RATE_NONE) [*2] |-> !periodicPulse && !tapLevel)
    else $error("Tap active with rate code none");

endmodule : rtc_divider
`default_nettype wire

//--- src/rtc_pkg.sv
// Shared constants and types of the clock control, flag and status block
package rtc_pkg;

  // Register addresses on the multiplexed bus
  localparam logic [7:0] ADDR_CONTROL = 8'h0b;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h0d;

  // Control register bit positions
  localparam int unsigned CTL_INHIBIT = 7;
  localparam int unsigned CTL_PIE = 6;
  localparam int unsigned CTL_AIE = 5;
  localparam int unsigned CTL_UIE = 4;
  localparam int unsigned CTL_SQUARE_WAVE_ENABLE = 3;
  localparam int unsigned CTL_NUMFMT = 2;
  localparam int unsigned CTL_HOUR24 = 1;
  localparam int unsigned CTL_DST = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Source flag vector positions (periodic, alarm, update-ended)
  localparam int unsigned FLG_PERIODIC = 2;
  localparam int unsigned FLG_ALARM = 1;
  localparam int unsigned FLG_UPDATE = 0;
  localparam logic [2:0] FLG_RESET = 3'h0;
  localparam logic [3:0] FLG_UNUSED = 4'h0;
  localparam logic [6:0] STS_UNUSED = 7'h00;

  // Alarm byte whose two top bits are set matches any time
  localparam logic [7:0] DONT_CARE_MASK = 8'hc0;

  // Update cycle lead time from progress flag to transfer
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned UIP_LEAD_US = 244;
  localparam int unsigned UIP_LEAD_CYCLES = UIP_LEAD_US * CLK_MHZ;
  localparam int unsigned LEAD_W = 16;

  // Divider chain and rate selection
  localparam int unsigned DIV_STAGES = 15;
  localparam logic [3:0] RATE_NONE = 4'h0;
  localparam logic [3:0] RATE_ALT_256 = 4'h1;
  localparam logic [3:0] RATE_ALT_128 = 4'h2;
  localparam logic [3:0] TAP_256 = 4'h6;
  localparam logic [3:0] TAP_128 = 4'h7;
  localparam logic [3:0] RATE_TAP_OFFSET = 4'h2;
  localparam logic [3:0] SECOND_TAP = 4'he;

  typedef enum logic {UPD_IDLE, UPD_LEAD} upd_state_t;

  // Maps a rate code to a divider stage index
  function automatic logic [3:0] tap_index(input logic [3:0] rate);
    if (rate == RATE_ALT_256) begin
      return TAP_256;
    end else if (rate == RATE_ALT_128) begin
      return TAP_128;
    end else begin
      return rate - RATE_TAP_OFFSET;
    end
  endfunction : tap_index

endpackage : rtc_pkg
